// ==== verilog/swc_defines.svh ====
// What this block does
// - Sleep entered only by sleep instruction
// - Sleep entry clears watchdog, keeps it counting
// - Sleep entry clears power-down, sets timeout flag
// - Oscillator driver off while asleep
// - Pins keep their pre-sleep drive state
// - Watchdog reset never drives master clear pin
// - Wake on master clear, watchdog, enabled interrupts
// - Master clear resets; others continue execution
// - Watchdog wake clears the timeout flag
// - Power-down flag set at power-up, cleared by sleep
// - Sleep prefetches instruction at PC plus one
// - Enabled source wakes regardless of global enable
// - Global enable clear: resume after sleep
// - Global enable set: run prefetched, vector 0004h
// - Pending enabled interrupt at sleep wakes immediately
// - Every wake clears the watchdog count
// - Crystal modes wait 1024 oscillator periods
`ifndef SWC_DEFINES_SVH
`define SWC_DEFINES_SVH
// Register byte addresses
`define SWC_ADR_CTRL 4'h0
`define SWC_ADR_STATUS 4'h4
`define SWC_ADR_IRQ 4'h8
// Control register fields
`define SWC_CTRL_WDT_EN 0
`define SWC_CTRL_GIE 1
`define SWC_CTRL_OSC_LO 2
`define SWC_CTRL_OSC_HI 3
// Status register fields
`define SWC_ST_PD 0
`define SWC_ST_TO 1
`define SWC_ST_ASLEEP 2
// Reset values
`define SWC_CTRL_RST 32'h0000_0000
`define SWC_IRQ_EN_RST 3'h0
// Timing
`define SWC_OST_PERIODS 1024
`define SWC_WDT_LIMIT 16'hFFFF
`define SWC_VECTOR 13'h0004
`define SWC_FLUSH_CYCLES 2
`endif

// ==== verilog/swc_pkg.sv ====
package swc_pkg;
    typedef enum logic [1:0] {
        SWC_OSC_LP,
        SWC_OSC_XT,
        SWC_OSC_HS,
        SWC_OSC_RC
    } swc_osc_e;
    typedef enum logic [2:0] {
        SWC_RUN,
        SWC_SLEEP,
        SWC_OST,
        SWC_FLUSH,
        SWC_VECT
    } swc_state_e;
endpackage : swc_pkg

// ==== verilog/swc_wdt.sv ====
`timescale 1ns/100ps
`include "swc_defines.svh"
module swc_wdt
    import swc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic clear,
    output logic timeout
);
    typedef struct packed {
        logic [15:0] count;
        logic timeout;
    } swc_wdt_s;
    swc_wdt_s st;
    swc_wdt_s next_st;

    // Count free, clear wins over expiry
    always_comb
    begin
        next_st = st;
        next_st.timeout = 1'b0;
        if (clear || !enable)
        begin
            next_st.count = 16'h0000;
        end
        else if (st.count == `SWC_WDT_LIMIT)
        begin
            next_st.count = 16'h0000;
            next_st.timeout = 1'b1;
        end
        else
        begin
            next_st.count = st.count + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
    assign timeout = st.timeout;
endmodule : swc_wdt

// ==== verilog/swc_ost.sv ====
`timescale 1ns/100ps
`include "swc_defines.svh"
module swc_ost
    import swc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic start,
    output logic busy
);
    typedef struct packed {
        logic [10:0] count;
        logic busy;
    } swc_ost_s;
    swc_ost_s st;
    swc_ost_s next_st;

    // Oscillator start-up countdown
    always_comb
    begin
        next_st = st;
        if (start)
        begin
            next_st.count = 11'(`SWC_OST_PERIODS - 1);
            next_st.busy = 1'b1;
        end
        else if (st.busy)
        begin
            if (st.count == 11'h000)
            begin
                next_st.busy = 1'b0;
            end
            else
            begin
                next_st.count = st.count - 11'h001;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
    assign busy = st.busy;
endmodule : swc_ost

// ==== verilog/swc_sleep_ctrl.sv ====
`timescale 1ns/100ps
`include "swc_defines.svh"
module swc_sleep_ctrl
    import swc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic sleep_exec,
    input wire logic [12:0] core_pc,
    input wire logic master_clear_pin,
    input wire logic [2:0] irq_flags,
    input wire logic [7:0] pin_out_i,
    input wire logic [7:0] pin_oe_i,
    output logic [7:0] pin_out_o,
    output logic [7:0] pin_oe_o,
    output logic osc_drive_en,
    output logic core_run,
    output logic core_reset,
    output logic prefetch_req,
    output logic [12:0] prefetch_addr,
    output logic vector_load,
    output logic [12:0] vector_addr,
    output logic flush_cycle
);
    typedef struct packed {
        swc_state_e state;
        logic wdt_en;
        logic global_irq_enable;
        swc_osc_e osc;
        logic pd;
        logic to;
        logic [2:0] irq_en;
        logic [1:0] flush_cnt;
        logic vec_pend;
        logic [31:0] dat_o;
        logic ack;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic osc_on;
        logic run;
        logic rst;
        logic pf_req;
        logic [12:0] pf_addr;
        logic vload;
        logic flush;
        logic wdt_clr;
        logic ost_start;
    } swc_ctl_s;
    swc_ctl_s st;
    swc_ctl_s next_st;

    logic wdt_to;
    logic ost_busy;
    logic irq_wake;
    logic bus_req;

    swc_wdt u_wdt (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .enable(st.wdt_en),
        .clear(st.wdt_clr),
        .timeout(wdt_to)
    );

    swc_ost u_ost (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .start(st.ost_start),
        .busy(ost_busy)
    );

    // per-source enable only, global enable ignored
    assign irq_wake = |(irq_flags & st.irq_en);
    assign bus_req = wb_cyc_i && wb_stb_i && !st.ack;

    always_comb
    begin
        next_st = st;
        next_st.ack = 1'b0;
        next_st.pf_req = 1'b0;
        next_st.vload = 1'b0;
        next_st.flush = 1'b0;
        next_st.wdt_clr = 1'b0;
        next_st.ost_start = 1'b0;
        next_st.rst = 1'b0;
        // Single-cycle bus slave; unmapped reads give zero
        if (bus_req)
        begin
            next_st.ack = 1'b1;
            next_st.dat_o = 32'h0000_0000;
            case (wb_adr_i)
                `SWC_ADR_CTRL:
                begin
                    if (wb_we_i && wb_sel_i[0])
                    begin
                        next_st.wdt_en = wb_dat_i[`SWC_CTRL_WDT_EN];
                        next_st.global_irq_enable = wb_dat_i[`SWC_CTRL_GIE];
                        next_st.osc = swc_osc_e'(
                            wb_dat_i[`SWC_CTRL_OSC_HI:`SWC_CTRL_OSC_LO]);
                    end
                    next_st.dat_o[`SWC_CTRL_WDT_EN] = st.wdt_en;
                    next_st.dat_o[`SWC_CTRL_GIE] = st.global_irq_enable;
                    next_st.dat_o[`SWC_CTRL_OSC_HI:`SWC_CTRL_OSC_LO] = st.osc;
                end
                `SWC_ADR_STATUS:
                begin
                    next_st.dat_o[`SWC_ST_PD] = st.pd;
                    next_st.dat_o[`SWC_ST_TO] = st.to;
                    next_st.dat_o[`SWC_ST_ASLEEP] = (st.state == SWC_SLEEP);
                end
                `SWC_ADR_IRQ:
                begin
                    if (wb_we_i && wb_sel_i[0])
                    begin
                        next_st.irq_en = wb_dat_i[2:0];
                    end
                    next_st.dat_o[2:0] = st.irq_en;
                end
                default:
                begin
                    next_st.dat_o = 32'h0000_0000;
                end
            endcase
        end
        // Pins follow the running core; held through start-up too
        if (st.run)
        begin
            next_st.pin_out = pin_out_i;
            next_st.pin_oe = pin_oe_i;
        end
        case (st.state)
            SWC_RUN:
            begin
                // only the sleep instruction enters sleep
                if (sleep_exec)
                begin
                    next_st.pf_req = 1'b1;
                    next_st.pf_addr = core_pc + 13'h0001;
                    next_st.wdt_clr = 1'b1;
                    next_st.pd = 1'b0;
                    next_st.to = 1'b1;
                    next_st.vec_pend = st.global_irq_enable;
                    if (irq_wake)
                    begin
                        next_st.wdt_clr = 1'b1;
                        next_st.state = SWC_RUN;
                        // Core runs the prefetched word before flushing
                        if (st.global_irq_enable)
                        begin
                            next_st.state = SWC_FLUSH;
                            next_st.flush_cnt = 2'(`SWC_FLUSH_CYCLES);
                        end
                    end
                    else
                    begin
                        next_st.state = SWC_SLEEP;
                        next_st.osc_on = 1'b0;
                        next_st.run = 1'b0;
                    end
                end
            end
            SWC_SLEEP:
            begin
                // wake decision; master clear via resetn
                if (wdt_to && st.wdt_en || irq_wake)
                begin
                    next_st.wdt_clr = 1'b1;
                    next_st.osc_on = 1'b1;
                    if (wdt_to && st.wdt_en)
                    begin
                        next_st.to = 1'b0;
                        next_st.vec_pend = 1'b0;
                    end
                    if (st.osc != SWC_OSC_RC)
                    begin
                        next_st.ost_start = 1'b1;
                    end
                    next_st.state = SWC_OST;
                end
            end
            SWC_OST:
            begin
                if (!ost_busy && !st.ost_start)
                begin
                    next_st.run = 1'b1;
                    // continue in-line when global enable clear
                    next_st.state = SWC_RUN;
                    if (st.vec_pend)
                    begin
                        next_st.state = SWC_FLUSH;
                        next_st.flush_cnt = 2'(`SWC_FLUSH_CYCLES);
                    end
                end
            end
            SWC_FLUSH:
            begin
                next_st.run = 1'b0;
                next_st.flush = 1'b1;
                if (st.flush_cnt == 2'h1)
                begin
                    next_st.state = SWC_VECT;
                end
                next_st.flush_cnt = st.flush_cnt - 2'h1;
            end
            SWC_VECT:
            begin
                next_st.vload = 1'b1;
                next_st.run = 1'b1;
                next_st.vec_pend = 1'b0;
                next_st.state = SWC_RUN;
            end
            default:
            begin
                next_st.state = SWC_RUN;
            end
        endcase
    end

    // master clear gives full reset; pin only an input
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            st <= '0;
            st.state <= SWC_RUN;
            st.pd <= 1'b1;
            st.to <= 1'b1;
            st.osc_on <= 1'b1;
            st.run <= 1'b1;
            st.rst <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign wb_dat_o = st.dat_o;
    assign wb_ack_o = st.ack;
    assign pin_out_o = st.pin_out;
    assign pin_oe_o = st.pin_oe;
    assign osc_drive_en = st.osc_on;
    assign core_run = st.run;
    assign core_reset = st.rst;
    assign prefetch_req = st.pf_req;
    assign prefetch_addr = st.pf_addr;
    assign vector_load = st.vload;
    assign vector_addr = `SWC_VECTOR;
    assign flush_cycle = st.flush;

    property p_sleep_flags;
        @(posedge ref_clk) disable iff (!resetn)
        (st.state == SWC_RUN && sleep_exec) |=> (!st.pd && st.to);
    endproperty
    a_sleep_flags: assert property (p_sleep_flags)
        else $error("flags wrong after sleep");

    property p_osc_off;
        @(posedge ref_clk) disable iff (!resetn)
        (st.state == SWC_SLEEP) |-> !osc_drive_en;
    endproperty
    a_osc_off: assert property (p_osc_off)
        else $error("oscillator on in sleep");

    property p_pins_hold;
        @(posedge ref_clk) disable iff (!resetn)
        (st.state == SWC_SLEEP && $past(st.state) == SWC_SLEEP)
            |-> $stable(pin_oe_o) && $stable(pin_out_o);
    endproperty
    a_pins_hold: assert property (p_pins_hold)
        else $error("pins moved in sleep");

    property p_prefetch;
        @(posedge ref_clk) disable iff (!resetn)
        (st.state == SWC_RUN && sleep_exec)
            |=> prefetch_req && prefetch_addr == $past(core_pc) + 13'h0001;
    endproperty
    a_prefetch: assert property (p_prefetch)
        else $error("no prefetch of pc plus one");

    property p_irq_wake;
        @(posedge ref_clk) disable iff (!resetn)
        (st.state == SWC_SLEEP && irq_wake) |=> st.state == SWC_OST;
    endproperty
    a_irq_wake: assert property (p_irq_wake)
        else $error("enabled interrupt did not wake");

    property p_wake_clr;
        @(posedge ref_clk) disable iff (!resetn)
        (st.state == SWC_SLEEP && next_st.state == SWC_OST)
            |=> st.wdt_clr;
    endproperty
    a_wake_clr: assert property (p_wake_clr)
        else $error("watchdog not cleared on wake");

    property p_wdt_to;
        @(posedge ref_clk) disable iff (!resetn)
        (st.state == SWC_SLEEP && wdt_to && st.wdt_en) |=> !st.to;
    endproperty
    a_wdt_to: assert property (p_wdt_to)
        else $error("timeout flag not cleared");

    property p_vector;
        @(posedge ref_clk) disable iff (!resetn)
        (st.state == SWC_FLUSH) |-> ##[1:3] vector_load;
    endproperty
    a_vector: assert property (p_vector)
        else $error("no vector after flush");
endmodule : swc_sleep_ctrl

// ==== bench/swc_core_model.sv ====
`timescale 1ns/100ps
module swc_core_model
    import swc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic sleep_go,
    input wire logic core_run,
    output logic sleep_exec,
    output logic [12:0] core_pc,
    output logic master_clear_pin,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);
    // sleep sits at 0100h, a no-op assumed after it
    assign core_pc = 13'h0100;
    // master clear held high unless reset intended
    assign master_clear_pin = resetn;
    // Core side: sleep only on command, pins churn while asleep
    always @(posedge ref_clk)
    begin
        // sleep issued only from a running core
        sleep_exec <= sleep_go && core_run === 1'b1;
        if (!resetn || core_run === 1'b1)
        begin
            pin_out <= 8'hA5;
            pin_oe <= 8'h3C;
        end
        else
        begin
            // Inputs change each cycle so a leaky freeze shows
            pin_out <= ~pin_out;
            pin_oe <= ~pin_oe;
        end
    end
endmodule : swc_core_model

// ==== bench/sleep_wakeup_controller_tb.sv ====
`timescale 1ns/100ps
`include "swc_defines.svh"
module sleep_wakeup_controller_tb
    import swc_pkg::*;
;
    logic ref_clk = 0, resetn = 0, we = 0, cyc = 0, stb = 0, go = 0;
    logic [3:0] adr = 0, sel = 0;
    logic [31:0] wd = 0, rd, q;
    logic [2:0] irq = 0;
    logic [7:0] po, pe, pin_out_o, pin_oe_o;
    logic [12:0] pc, pa, vector_addr, prefetch_addr;
    logic sx, mc, ack, osc, run, crst, pf, vl, fl;
    int fails = 0, checks_done = 0, nvec, nfl, nrst, n;
    swc_core_model core (.ref_clk(ref_clk), .resetn(resetn),
        .sleep_go(go), .core_run(run), .sleep_exec(sx), .core_pc(pc),
        .master_clear_pin(mc), .pin_out(po), .pin_oe(pe));
    swc_sleep_ctrl dut (.ref_clk(ref_clk), .resetn(resetn),
        .wb_adr_i(adr), .wb_dat_i(wd), .wb_dat_o(rd), .wb_we_i(we),
        .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .sleep_exec(sx), .core_pc(pc), .master_clear_pin(mc),
        .irq_flags(irq), .pin_out_i(po), .pin_oe_i(pe),
        .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .osc_drive_en(osc),
        .core_run(run), .core_reset(crst), .prefetch_req(pf),
        .prefetch_addr(prefetch_addr), .vector_load(vl),
        .vector_addr(vector_addr), .flush_cycle(fl));
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    // Pulse outputs are tallied here so no single cycle is missed
    always @(posedge ref_clk)
    begin
        nvec += (vl === 1'b1);
        nfl += (fl === 1'b1);
        nrst += (crst === 1'b1);
    end
    task tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : tick
    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    // Classic cycle; held until ack is sampled high
    task wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        adr <= a;
        we <= w;
        wd <= d;
        sel <= 4'hF;
        cyc <= 1;
        stb <= 1;
        k = 0;
        do @(posedge ref_clk); while (ack !== 1'b1 && ++k < 50);
        q = rd;
        cyc <= 0;
        stb <= 0;
        chk(k < 50, 1, "bus hang");
    endtask : wb
    task sleep;
        int k;
        @(posedge ref_clk);
        go <= 1;
        @(posedge ref_clk);
        go <= 0;
        k = 0;
        do tick(1); while (pf !== 1'b1 && ++k < 10);
        pa = prefetch_addr;
        nvec = 0;
        nfl = 0;
        nrst = 0;
    endtask : sleep
    // Cycles from oscillator restart to core run land in n
    task wake(input int lim);
        int k;
        k = 0;
        while (osc !== 1'b1 && k < lim)
        begin
            tick(1);
            k++;
        end
        chk(k < lim, 1, "no wake");
        n = 0;
        while (run !== 1'b1 && n < 2000)
        begin
            tick(1);
            n++;
        end
        tick(10);
    endtask : wake
    task t_reset;
        wb(`SWC_ADR_STATUS, 0, 0);
        chk(q, 32'h0000_0003, "status reset");
        wb(`SWC_ADR_CTRL, 0, 0);
        chk(q, 32'h0000_0000, "ctrl reset");
        wb(4'hC, 0, 0);
        chk(q, 32'h0000_0000, "unmapped read");
        $display("reset test done");
    endtask : t_reset
    task t_osc;
        for (int m = 0; m < 4; m++)
        begin
            wb(`SWC_ADR_CTRL, 1, m << 2);
            wb(`SWC_ADR_IRQ, 1, 32'h0000_0001);
            sleep();
            irq <= 3'h1;
            wake(100);
            irq <= 3'h0;
            // start-up wait except in the rc mode
            chk(m == 3 ? n <= 3 : n >= 1024 && n <= 1027, 1, "startup");
        end
        $display("oscillator test done");
    endtask : t_osc
    task t_irq(input logic global_irq_enable);
        wb(`SWC_ADR_CTRL, 1, 32'h0000_000C | global_irq_enable << 1);
        wb(`SWC_ADR_IRQ, 1, 32'h0000_0001);
        sleep();
        chk(pa, 13'h0101, "prefetch addr");
        chk(osc, 0, "osc while asleep");
        chk(run, 0, "core run");
        wb(`SWC_ADR_STATUS, 0, 0);
        chk(q, 32'h0000_0006, "status asleep");
        tick(5);
        chk({pin_out_o, pin_oe_o}, 16'hA53C, "pins frozen");
        irq <= 3'h2;
        tick(20);
        chk(osc, 0, "disabled source woke");
        irq <= 3'h1;
        wake(20);
        irq <= 3'h0;
        chk(nrst, 0, "reset on irq wake");
        chk(nvec, global_irq_enable, "vector pulse");
        chk(vector_addr, 13'h0004, "vector addr");
        chk(nfl, global_irq_enable ? 2 : 0, "flush cycles");
        $display("irq test done");
    endtask : t_irq
    // Sleep with an enabled flag already up must not stop the core
    task t_pending(input logic global_irq_enable);
        wb(`SWC_ADR_CTRL, 1, 32'h0000_000C | global_irq_enable << 1);
        irq <= 3'h1;
        tick(2);
        sleep();
        chk({run, osc}, 2'h3, "pending irq wake");
        tick(10);
        chk(nvec, global_irq_enable, "pending vector");
        chk(nfl, global_irq_enable ? 2 : 0, "pending flush");
        irq <= 3'h0;
        $display("pending test done");
    endtask : t_pending
    task t_wdt;
        wb(`SWC_ADR_IRQ, 1, 32'h0000_0000);
        wb(`SWC_ADR_CTRL, 1, 32'h0000_000D);
        sleep();
        wake(70000);
        wb(`SWC_ADR_STATUS, 0, 0);
        chk(q, 32'h0000_0000, "status after wdt");
        chk(nrst + nvec, 0, "wdt wake reset");
        $display("watchdog test done");
    endtask : t_wdt
    task t_master_clear_pin;
        wb(`SWC_ADR_CTRL, 1, 32'h0000_000C);
        sleep();
        resetn <= 0;
        tick(2);
        chk({crst, osc}, 2'h3, "master clear");
        resetn <= 1;
        tick(2);
        wb(`SWC_ADR_STATUS, 0, 0);
        chk(q, 32'h0000_0003, "status after clear");
        $display("master clear test done");
    endtask : t_master_clear_pin
    task final_report;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // Watchdog sized well past the slow watchdog wake
    initial
    begin
        #900_000;
        fails++;
        $display("[ERR] %0t run timed out", $time);
        final_report();
    end
    initial
    begin
        tick(4);
        resetn <= 1;
        t_reset();
        t_osc();
        t_irq(0);
        t_irq(1);
        t_pending(0);
        t_pending(1);
        t_wdt();
        t_master_clear_pin();
        final_report();
    end
endmodule : sleep_wakeup_controller_tb
